// ===== core/fist_pkg.sv
// package: register map, field layout and timing constants of the flash irq / tick_reload_value tick block
package fist_pkg;
   localparam logic [11:0] FIST_MASK_OFF    = 12'h010;
   localparam logic [11:0] FIST_MISC_OFF    = 12'h014;
   localparam logic [11:0] FIST_RIS_OFF     = 12'h00C;
   localparam logic [11:0] FIST_PULSE_OFF   = 12'h018;
   localparam logic [11:0] FIST_TICK_RELOAD_VALUE_OFF    = 12'h140;
   localparam int          FIST_ACC_BIT     = 0;
   localparam int          FIST_PROG_BIT    = 1;
   localparam logic [7:0]  FIST_TICK_RELOAD_VALUE_RST    = 8'h31;
   localparam logic [15:0] FIST_PULSE_RST   = 16'h0014;
   localparam int          FIST_CLK_MHZ     = 100;
   localparam int          FIST_PULSE_W     = 16;
endpackage : fist_pkg

// ===== core/fist_tick_div.sv
// module: reloadable down-counter producing a one-cycle microsecond tick enable
`timescale 1ns/100ps
`default_nettype none
module fist_tick_div
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] reload,
   output logic            tick
);
   logic [7:0] count_r;

   // reload from the current value on every tick, so a new value acts at the next period
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_r <= fist_pkg::FIST_TICK_RELOAD_VALUE_RST;
         tick    <= 1'b0;
      end
      else if (count_r == 8'h00)
      begin
         count_r <= reload;
         tick    <= 1'b1;
      end
      else
      begin
         count_r <= count_r - 8'h01;
         tick    <= 1'b0;
      end
   end
endmodule // fist_tick_div
`default_nettype wire

// ===== core/fist_core.sv
// module: flash irq status, mask, clear and microsecond-timed write pulse over AHB-Lite
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - masked status at 0x014: bit 1 programming done, bit 0 access violation.
// - writing one to a masked status bit clears it; zero leaves it.
// - mask bits at 0x010 gate masked status and the interrupt output.
// - 8-bit reload divides the clock into a 1 us tick, reloaded each tick.
// - the high-voltage write pulse is timed in microsecond ticks.
// - reload resets to 0x31 for 50 MHz operation.
module fist_core
(
   input  wire logic        CLOCK,
   input  wire logic        RSTN,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        PROG_DONE,
   input  wire logic        ACCESS_VIOL,
   input  wire logic        PULSE_START,
   output logic             HV_PULSE,
   output logic             TICK_RELOAD_VALUE_TICK,
   output logic             IRQ
);
   logic [1:0]  raw_r;
   logic [1:0]  mask_r;
   logic [7:0]  tick_reload_value_r;
   logic [15:0] pulse_len_r;
   logic [15:0] pulse_cnt_r;
   logic        wr_pend_r;
   logic [11:0] wr_addr_r;
   logic [1:0]  masked;
   logic [1:0]  clr;
   logic [1:0]  evt;
   logic        tick;
   logic        addr_ok;

   // ---------------------------------------------------------------
   // ahb-lite slave: zero wait states, always OKAY
   // ---------------------------------------------------------------
   assign addr_ok = HSEL && HREADY && HTRANS[1];
   assign masked  = raw_r & mask_r;

   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 12'h000;
      end
      else if (HREADY)
      begin
         wr_pend_r <= addr_ok && HWRITE;
         wr_addr_r <= HADDR[11:0];
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         HRDATA    <= 32'h0000_0000;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
      else if (addr_ok && !HWRITE)
      begin
         unique case (HADDR[11:0])
            fist_pkg::FIST_RIS_OFF:   HRDATA <= {30'h0000_0000, raw_r};
            fist_pkg::FIST_MASK_OFF:  HRDATA <= {30'h0000_0000, mask_r};
            fist_pkg::FIST_MISC_OFF:  HRDATA <= {30'h0000_0000, masked};
            fist_pkg::FIST_PULSE_OFF: HRDATA <= {16'h0000, pulse_len_r};
            fist_pkg::FIST_TICK_RELOAD_VALUE_OFF:  HRDATA <= {24'h00_0000, tick_reload_value_r};
            default:                  HRDATA <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         mask_r      <= 2'b00;
         tick_reload_value_r      <= fist_pkg::FIST_TICK_RELOAD_VALUE_RST;
         pulse_len_r <= fist_pkg::FIST_PULSE_RST;
      end
      else if (wr_pend_r)
      begin
         if (wr_addr_r == fist_pkg::FIST_MASK_OFF)
            mask_r <= HWDATA[1:0];
         if (wr_addr_r == fist_pkg::FIST_TICK_RELOAD_VALUE_OFF)
            tick_reload_value_r <= HWDATA[7:0];
         if (wr_addr_r == fist_pkg::FIST_PULSE_OFF)
            pulse_len_r <= HWDATA[15:0];
      end
   end

   // ---------------------------------------------------------------
   // status: sticky raw bits, w1c through the masked view
   // ---------------------------------------------------------------
   assign evt = {PROG_DONE, ACCESS_VIOL};
   assign clr = (wr_pend_r && wr_addr_r == fist_pkg::FIST_MISC_OFF) ? HWDATA[1:0] : 2'b00;

   // set wins over clear so an event in the clearing cycle is kept
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
         raw_r <= 2'b00;
      else
         raw_r <= (raw_r & ~clr) | evt;
   end

   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
         IRQ <= 1'b0;
      else
         IRQ <= |(((raw_r & ~clr) | evt) & mask_r);
   end

   // ---------------------------------------------------------------
   // microsecond tick and high-voltage pulse timing
   // ---------------------------------------------------------------
   fist_tick_div u_div
   (
      .clk    (CLOCK),
      .rst_n  (RSTN),
      .reload (tick_reload_value_r),
      .tick   (tick)
   );

   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
         TICK_RELOAD_VALUE_TICK <= 1'b0;
      else
         TICK_RELOAD_VALUE_TICK <= tick;
   end

   // pulse length counts whole ticks; start is ignored while a pulse runs
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         pulse_cnt_r <= 16'h0000;
         HV_PULSE    <= 1'b0;
      end
      else if (!HV_PULSE && PULSE_START && pulse_len_r != 16'h0000)
      begin
         pulse_cnt_r <= pulse_len_r;
         HV_PULSE    <= 1'b1;
      end
      else if (HV_PULSE && tick)
      begin
         if (pulse_cnt_r == 16'h0001)
            HV_PULSE <= 1'b0;
         pulse_cnt_r <= pulse_cnt_r - 16'h0001;
      end
   end
endmodule // fist_core
`default_nettype wire

// ===== tb/fist_checker.sv
// checker: port properties of the flash irq and tick block
`timescale 1ns/100ps
`default_nettype none
module fist_checker
(
   input wire logic        CLOCK,
   input wire logic        RSTN,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   input wire logic        PROG_DONE,
   input wire logic        ACCESS_VIOL,
   input wire logic        TICK_RELOAD_VALUE_TICK,
   input wire logic        HV_PULSE,
   input wire logic        IRQ
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   wire rd = HTRANS[1] && !HWRITE;
   a_bus_okay:
      assert property (HREADYOUT && !HRESP) else $error("bus not okay");
   a_misc_upper:
      assert property (rd && HADDR[11:0] == 12'h014 |=> HRDATA[31:2] == 30'h0) else $error("st");
   a_tick_reload_value_upper:
      assert property (rd && HADDR[11:0] == 12'h140 |=> HRDATA[31:8] == 24'h0) else $error("rl");
   a_unmapped_zero:
      assert property (rd && HADDR[11:0] == 12'h100 |=> HRDATA == 32'h0) else $error("unmap");
   a_tick_single:
      assert property (TICK_RELOAD_VALUE_TICK |=> !TICK_RELOAD_VALUE_TICK) else $error("tick long");
   a_pulse_tick:
      assert property ($fell(HV_PULSE) |-> TICK_RELOAD_VALUE_TICK) else $error("pulse off tick");
   a_irq_rise:
      assert property ($rose(IRQ) |-> $past(PROG_DONE || ACCESS_VIOL) || $past(HWRITE, 3))
         else $error("irq rose");
   a_irq_fall:
      assert property ($fell(IRQ) |-> $past(HWRITE, 2) || $past(HWRITE, 3))
         else $error("irq fell");
   c_irq: cover property ($rose(IRQ));
   c_pulse: cover property ($fell(HV_PULSE));
   c_unmap: cover property (rd && HADDR[11:0] == 12'h100);
endmodule // fist_checker
`default_nettype wire

// ===== tb/fist_flash_model.sv
// partner: flash array that counts pulse ticks and reports completion
`timescale 1ns/100ps
`default_nettype none
module fist_flash_model
(
   input  wire logic clk,
   input  wire logic hv_pulse,
   input  wire logic tick_reload_value_tick,
   output logic      prog_done,
   output logic [7:0] tick_cnt_r
);
   logic hv_r = 1'b0;
   initial prog_done = 1'b0;
   initial tick_cnt_r = 8'h00;
   // completion only after the pulse has really ended
   always @(posedge clk)
   begin
      hv_r <= hv_pulse;
      prog_done <= hv_r && !hv_pulse;
      if (hv_pulse && !hv_r)
         tick_cnt_r <= 8'h00;
      else if (hv_r && tick_reload_value_tick)
         tick_cnt_r <= tick_cnt_r + 8'h01;
   end
endmodule // fist_flash_model
`default_nettype wire

// ===== tb/fist_core_tb.sv
// testbench: registers, tick, pulse and interrupts of the flash irq block
`timescale 1ns/100ps
`default_nettype none
module fist_core_tb;
   logic CLOCK = 0, RSTN = 0, HWRITE = 0, ACCESS_VIOL = 0, PULSE_START = 0;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, q;
   logic [1:0] HTRANS = 2'h0;
   logic HREADYOUT, HRESP, HV_PULSE, TICK_RELOAD_VALUE_TICK, IRQ, PROG_DONE;
   logic [7:0] ticks;
   int failures = 0, comparisons = 0, cyc = 0, t;
   logic [75:0] rows [5] = '{{12'h140, 32'hFFFF_FF63, 32'h63}, {12'h010, 32'hFFFF_FFFF, 32'h3},
      {12'h018, 32'h3, 32'h3}, {12'h100, 32'hFFFF_FFFF, 32'h0}, {12'h00C, 32'hFFFF_FFFF, 32'h0}};
   always #5 CLOCK = ~CLOCK;
   fist_core dut (.CLOCK, .RSTN, .HSEL(1'b1), .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
      .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .PROG_DONE, .ACCESS_VIOL, .PULSE_START,
      .HV_PULSE, .TICK_RELOAD_VALUE_TICK, .IRQ);
   fist_flash_model fm (.clk(CLOCK), .hv_pulse(HV_PULSE), .tick_reload_value_tick(TICK_RELOAD_VALUE_TICK),
      .prog_done(PROG_DONE), .tick_cnt_r(ticks));
   task automatic end_sim;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      HTRANS <= 2'h2;
      HWRITE <= w;
      HADDR <= {20'h0_0000, a};
      do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
      q = HRDATA;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
      bus(1'b0, a, 32'h0);
      chk(n, q, e);
   endtask
   always @(posedge CLOCK)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         failures++;
         end_sim;
      end
   end
   initial
   begin
      repeat (16) @(posedge CLOCK);
      RSTN <= 1'b1;
      @(posedge CLOCK);
      rd(12'h140, 32'h31, "reload reset");
      rd(12'h014, 32'h0, "status reset");
      foreach (rows[i])
      begin
         bus(1'b1, rows[i][75:64], rows[i][63:32]);
         rd(rows[i][75:64], rows[i][31:0], "register row");
      end
      do @(posedge CLOCK); while (TICK_RELOAD_VALUE_TICK !== 1'b1);
      t = cyc;
      do @(posedge CLOCK); while (TICK_RELOAD_VALUE_TICK !== 1'b1);
      chk("tick period", cyc - t, 32'd100);
      $display("test registers done");
      @(posedge CLOCK);
      PULSE_START <= 1'b1;
      @(posedge CLOCK);
      PULSE_START <= 1'b0;
      wait (IRQ === 1'b1);
      @(posedge CLOCK);
      chk("pulse ticks", ticks, 32'h3);
      rd(12'h014, 32'h2, "masked prog");
      bus(1'b1, 12'h014, 32'h0);
      rd(12'h014, 32'h2, "zero write");
      bus(1'b1, 12'h014, 32'h2);
      rd(12'h00C, 32'h0, "raw cleared");
      chk("irq cleared", IRQ, 32'h0);
      $display("test pulse done");
      bus(1'b1, 12'h010, 32'h2);
      ACCESS_VIOL <= 1'b1;
      @(posedge CLOCK);
      ACCESS_VIOL <= 1'b0;
      rd(12'h00C, 32'h1, "raw access");
      rd(12'h014, 32'h0, "masked access");
      chk("irq masked", IRQ, 32'h0);
      bus(1'b1, 12'h010, 32'h3);
      rd(12'h014, 32'h1, "unmasked access");
      chk("irq unmasked", IRQ, 32'h1);
      $display("test access done");
      end_sim;
   end
endmodule // fist_core_tb
bind fist_core fist_checker chk_i (.CLOCK, .RSTN, .HADDR, .HTRANS, .HWRITE, .HRDATA, .HREADYOUT,
   .HRESP, .PROG_DONE, .ACCESS_VIOL, .TICK_RELOAD_VALUE_TICK, .HV_PULSE, .IRQ);
`default_nettype wire
